// file: core/oiwp_fifo.sv
// Purpose: Small FIFO between the I2C receiver and the byte consumer.
// Assumes: Writer and reader share one clock.
// Notes: All outputs are registered; ready is set from the next fill level and drops as the last slot fills.
module oiwp_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 8
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_wr_valid,
	input wire logic [WIDTH-1:0] i_wr_data,
	output logic o_wr_ready,
	output logic o_rd_valid,
	output logic [WIDTH-1:0] o_rd_data,
	input wire logic i_rd_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	// Storage words.
	logic [WIDTH-1:0] mem [DEPTH];
	// Write and read positions.
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	// Words held, including the one shown at the output.
	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic [AW-1:0] next_rd_ptr;
	logic push;
	logic pop;

	assign push = i_wr_valid && o_wr_ready;
	assign pop = o_rd_valid && i_rd_ready;

	// Work out the fill level and read position of the next cycle.
	always_comb
	begin
		next_count = count;
		next_rd_ptr = rd_ptr;
		if (push && !pop)
			next_count = count + CW'(1);
		else if (!push && pop)
			next_count = count - CW'(1);
		if (pop)
			next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
	end

	// Store pushed words.
	always_ff @(posedge i_clk)
	begin
		if (push)
			mem[wr_ptr] <= i_wr_data;
	end

	// Pointers, level and flags; the output word is presented from a register.
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			o_wr_ready <= 1'b0;
			o_rd_valid <= 1'b0;
			o_rd_data <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			o_wr_ready <= (next_count < CW'(DEPTH));
			o_rd_valid <= (next_count != '0);
			// A word written into an empty head bypasses the memory.
			if (push && next_rd_ptr == wr_ptr)
				o_rd_data <= i_wr_data;
			else
				o_rd_data <= mem[next_rd_ptr];
		end
	end
endmodule // oiwp_fifo

// file: core/oiwp_pkg.sv
// Purpose: Shared constants and types of the display controller I2C write port.
// Assumes: One system clock; the I2C pins are sampled, never used as clocks.
// Notes: Protocol numbers and multi-bit defaults are named here; one-bit defaults are written in the logic.
package oiwp_pkg;

	// Upper six bits of the slave address; the low bit is the select pin.
	localparam logic [5:0] ADDR_BASE = 6'h1e;
	// Read/write bit value that opens write mode.
	localparam logic RW_WRITE = 1'h0;
	// Bits in one byte before the acknowledge clock.
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	// Positions of the flags inside a control byte.
	localparam int CTRL_CONT_POS = 7;
	localparam int CTRL_SEL_POS = 6;
	// Select value that routes a byte to the display RAM.
	localparam logic SEL_DATA = 1'h1;
	// Continuation value that turns the rest into a data stream.
	localparam logic CONT_STREAM = 1'h0;
	// Number of synchronised pins and their slots.
	localparam int NUM_SYNC = 4;
	localparam int SYNC_SCL = 0;
	localparam int SYNC_SDA = 1;
	localparam int SYNC_SA = 2;
	localparam int SYNC_INIT = 3;
	// Stages in each pin synchroniser.
	localparam int SYNC_STAGES = 3;
	// Idle level of every synchronised pin after reset.
	localparam logic [2:0] SYNC_RST = 3'h7;
	// Default values loaded while the chip is initialised, and the column step.
	localparam logic [7:0] CONTRAST_INIT = 8'h80;
	localparam logic [5:0] START_LINE_INIT = 6'h00;
	localparam logic [7:0] COLUMN_INIT = 8'h00;
	localparam logic [7:0] SHIFT_INIT = 8'h00;
	localparam logic [7:0] COLUMN_STEP = 8'h01;
	// Default depth of the output FIFO.
	localparam int FIFO_DEPTH = 8;

	// One byte handed to the command path or the display RAM.
	typedef struct packed {
		logic is_data;
		logic [7:0] column;
		logic [7:0] value;
	} oiwp_word_t;

	// Receiver states of the write port.
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_CTRL,
		ST_ONE,
		ST_STREAM,
		ST_IGNORE
	} oiwp_state_t;

endpackage

// file: core/oiwp_top.sv
// Purpose: I2C slave write port of a passive-matrix display controller.
// Assumes: SCL and SDA are slow against the 50 MHz system clock.
// Notes: Read mode is recognised but not served; bytes leave through a FIFO.
module oiwp_top #(
	parameter int FIFO_DEPTH = oiwp_pkg::FIFO_DEPTH
) (
	// System clock.
	input wire logic i_clk,
	// Asynchronous reset, active high.
	input wire logic i_rst,
	// I2C clock pin.
	input wire logic i_scl,
	// I2C data pin, input side.
	input wire logic i_sda,
	// Address select pin, shared with the data/command pin.
	input wire logic i_slave_addr_select,
	// Chip initialisation, active low.
	input wire logic i_chip_init_n,
	// Consumer takes the output word.
	input wire logic i_out_ready,
	// I2C data pin, driven value.
	output logic o_sda_out,
	// I2C data pin enable, low while the pin is pulled down.
	output logic o_sda_oe_n,
	// Output word present.
	output logic o_out_valid,
	// Byte for the command path or the display RAM.
	output oiwp_pkg::oiwp_word_t o_out_word,
	// A byte was lost because the FIFO was full.
	output logic o_overflow,
	// A transaction is open.
	output logic o_busy,
	// Display panel switched on.
	output logic o_display_on,
	// Full 132 x 64 multiplex mode.
	output logic o_mux_full,
	// Row outputs scan in normal direction.
	output logic o_com_scan_normal,
	// Column and row drivers mapped from address zero.
	output logic o_seg_map_normal,
	// First display RAM line shown.
	output logic [5:0] o_start_line,
	// Display RAM column pointer.
	output logic [7:0] o_column,
	// Contrast control register.
	output logic [7:0] o_contrast,
	// Normal display mode, not entire-on.
	output logic o_display_normal
);

	// Three-stage synchronisers, one per pin.
	logic [oiwp_pkg::SYNC_STAGES-1:0] sync [oiwp_pkg::NUM_SYNC];
	// Filtered pin levels, updated once the last two stages agree.
	logic [oiwp_pkg::NUM_SYNC-1:0] flt;
	// Filtered levels one cycle earlier, for edge finding.
	logic scl_q;
	logic sda_q;
	// Bus events.
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	// Chip initialisation in force.
	logic init_active;
	// Receiver state.
	oiwp_pkg::oiwp_state_t state;
	// Bits received in the current byte.
	logic [3:0] bit_cnt;
	// Serial shift register.
	logic [7:0] shreg;
	// Acknowledge clock in progress.
	logic ack_drive;
	// Acknowledge flag of the next cycle.
	logic next_ack_drive;
	// Latched command/data select of the last control byte.
	logic sel;
	// A complete byte stands in the shift register.
	logic byte_done;
	// Address match of the received byte.
	logic addr_hit;
	// Request toward the FIFO.
	logic push_valid;
	oiwp_pkg::oiwp_word_t push_word;
	logic fifo_ready;

	// Every pin passes three flops; the first is read by the second only.
	for (genvar g = 0; g < oiwp_pkg::NUM_SYNC; g++)
	begin : g_sync
		logic pin;
		assign pin = (g == oiwp_pkg::SYNC_SCL) ? i_scl :
			(g == oiwp_pkg::SYNC_SDA) ? i_sda :
			(g == oiwp_pkg::SYNC_SA) ? i_slave_addr_select : i_chip_init_n;
		always_ff @(posedge i_clk or posedge i_rst)
		begin
			if (i_rst)
			begin
				sync[g] <= oiwp_pkg::SYNC_RST;
				flt[g] <= 1'b1;
			end
			else
			begin
				sync[g] <= {sync[g][1:0], pin};
				// A change counts once stages two and three agree.
				if (sync[g][1] == sync[g][2])
					flt[g] <= sync[g][2];
			end
		end
	end

	// Previous filtered SCL and SDA levels.
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= flt[oiwp_pkg::SYNC_SCL];
			sda_q <= flt[oiwp_pkg::SYNC_SDA];
		end
	end

	assign scl_rise = flt[oiwp_pkg::SYNC_SCL] && !scl_q;
	assign scl_fall = !flt[oiwp_pkg::SYNC_SCL] && scl_q;
	assign start_seen = flt[oiwp_pkg::SYNC_SCL] && scl_q && sda_q && !flt[oiwp_pkg::SYNC_SDA];
	assign stop_seen = flt[oiwp_pkg::SYNC_SCL] && scl_q && !sda_q && flt[oiwp_pkg::SYNC_SDA];
	assign init_active = !flt[oiwp_pkg::SYNC_INIT];
	// sample on rise: SDA data bits are read at SCL rising edges; start and stop are seen while SCL is high.
	assign byte_done = scl_fall && !ack_drive && (bit_cnt == oiwp_pkg::BITS_PER_BYTE);
	assign addr_hit = (shreg[7:1] == {oiwp_pkg::ADDR_BASE, flt[oiwp_pkg::SYNC_SA]});

	// Bit counter and shift register follow SCL edges.
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			bit_cnt <= '0;
			shreg <= oiwp_pkg::SHIFT_INIT;
		end
		else if (init_active)
		begin
			bit_cnt <= '0;
			shreg <= oiwp_pkg::SHIFT_INIT;
		end
		else if (start_seen || stop_seen)
		begin
			// A fresh byte begins after any start or stop.
			bit_cnt <= '0;
		end
		else if (byte_done)
		begin
			// The acknowledge clock is not a data bit.
			bit_cnt <= '0;
		end
		else if (scl_rise && !ack_drive && bit_cnt != oiwp_pkg::BITS_PER_BYTE)
		begin
			// Bits arrive most significant first.
			shreg <= {shreg[6:0], flt[oiwp_pkg::SYNC_SDA]};
			bit_cnt <= bit_cnt + 4'h1;
		end
	end

	// Receiver sequencing through address, control and data bytes.
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			state <= oiwp_pkg::ST_IDLE;
		else if (init_active)
			state <= oiwp_pkg::ST_IDLE;
		else if (start_seen)
			state <= oiwp_pkg::ST_ADDR;
		else if (stop_seen)
			state <= oiwp_pkg::ST_IDLE;
		else if (byte_done)
		begin
			unique case (state)
				oiwp_pkg::ST_IDLE:
					state <= oiwp_pkg::ST_IDLE;
				oiwp_pkg::ST_ADDR:
				begin
					if (addr_hit && shreg[0] == oiwp_pkg::RW_WRITE)
						state <= oiwp_pkg::ST_CTRL;
					else
						state <= oiwp_pkg::ST_IGNORE;
				end
				oiwp_pkg::ST_CTRL:
				begin
					if (shreg[oiwp_pkg::CTRL_CONT_POS] == oiwp_pkg::CONT_STREAM)
						state <= oiwp_pkg::ST_STREAM;
					else
						state <= oiwp_pkg::ST_ONE;
				end
				oiwp_pkg::ST_ONE:
					state <= oiwp_pkg::ST_CTRL;
				oiwp_pkg::ST_STREAM:
					state <= oiwp_pkg::ST_STREAM;
				oiwp_pkg::ST_IGNORE:
					state <= oiwp_pkg::ST_IGNORE;
			endcase
		end
	end

	// Acknowledge drive: SDA low over the whole ninth clock.
	always_comb
	begin
		next_ack_drive = ack_drive;
		if (init_active || start_seen || stop_seen)
			next_ack_drive = 1'b0;
		else if (byte_done)
		begin
			if (state == oiwp_pkg::ST_ADDR)
				next_ack_drive = addr_hit && (shreg[0] == oiwp_pkg::RW_WRITE);
			else
				next_ack_drive = (state == oiwp_pkg::ST_CTRL || state == oiwp_pkg::ST_ONE ||
					state == oiwp_pkg::ST_STREAM);
		end
		else if (scl_fall)
			// The falling edge after the ninth clock releases the line.
			next_ack_drive = 1'b0;
	end

	// Flag and pin enable load at the same edge, so the pull-down starts a clock sooner.
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			ack_drive <= 1'b0;
			o_sda_out <= 1'b0;
			o_sda_oe_n <= 1'b1;
		end
		else
		begin
			ack_drive <= next_ack_drive;
			// The pin only ever pulls low.
			o_sda_out <= 1'b0;
			o_sda_oe_n <= !next_ack_drive;
		end
	end

	// Latch the command/data select from each control byte.
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			sel <= 1'b0;
		else if (init_active)
			sel <= 1'b0;
		else if (byte_done && state == oiwp_pkg::ST_CTRL)
			sel <= shreg[oiwp_pkg::CTRL_SEL_POS];
	end

	// Hand finished command and data bytes to the FIFO.
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			push_valid <= 1'b0;
			push_word <= '0;
		end
		else
		begin
			push_valid <= 1'b0;
			if (!init_active && byte_done &&
				(state == oiwp_pkg::ST_ONE || state == oiwp_pkg::ST_STREAM))
			begin
				push_valid <= 1'b1;
				push_word.is_data <= (sel == oiwp_pkg::SEL_DATA);
				push_word.column <= o_column;
				push_word.value <= shreg;
			end
		end
	end

	// Column pointer steps after each accepted RAM byte.
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			o_column <= oiwp_pkg::COLUMN_INIT;
		else if (init_active)
			o_column <= oiwp_pkg::COLUMN_INIT;
		else if (push_valid && fifo_ready && push_word.is_data)
			o_column <= o_column + oiwp_pkg::COLUMN_STEP;
	end

	// Sticky loss flag; a full FIFO cannot stall the I2C master.
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			o_overflow <= 1'b0;
		else if (push_valid && !fifo_ready)
			o_overflow <= 1'b1;
		else if (init_active)
			o_overflow <= 1'b0;
	end

	// Transaction open flag for the rest of the chip.
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			o_busy <= 1'b0;
		else
			o_busy <= (state != oiwp_pkg::ST_IDLE);
	end

	// Display settings take their defaults while initialisation is held.
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_display_on <= 1'b0;
			o_mux_full <= 1'b1;
			o_com_scan_normal <= 1'b1;
			o_seg_map_normal <= 1'b1;
			o_start_line <= oiwp_pkg::START_LINE_INIT;
			o_contrast <= oiwp_pkg::CONTRAST_INIT;
			o_display_normal <= 1'b1;
		end
		else if (init_active)
		begin
			o_display_on <= 1'b0;
			o_mux_full <= 1'b1;
			o_com_scan_normal <= 1'b1;
			o_seg_map_normal <= 1'b1;
			o_start_line <= oiwp_pkg::START_LINE_INIT;
			o_contrast <= oiwp_pkg::CONTRAST_INIT;
			o_display_normal <= 1'b1;
		end
	end

	// Output FIFO; its ready gates the push and the column step.
	oiwp_fifo #(
		.WIDTH($bits(oiwp_pkg::oiwp_word_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_wr_valid(push_valid),
		.i_wr_data(push_word),
		.o_wr_ready(fifo_ready),
		.o_rd_valid(o_out_valid),
		.o_rd_data(o_out_word),
		.i_rd_ready(i_out_ready)
	);

endmodule // oiwp_top

// file: test/oiwp_bench.sv
// Purpose: Self-checking bench for the write port.
// Assumes: Master model drives the bus; bench consumes words.
// Notes: Random payloads come from a fixed seed.
module oiwp_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sel_pin = 1'b0;
	logic init_n = 1'b1;
	logic rdy = 1'b0;
	logic stall = 1'b0;
	logic scl, sda_drv, sda, sda_out, sda_oe_n, valid, ovf, busy;
	logic disp_on, mux, scan, segmap, dnorm;
	logic [5:0] sline;
	logic [7:0] col, contrast, e_col, base;
	logic e_sel;
	oiwp_pkg::oiwp_word_t word;
	oiwp_pkg::oiwp_word_t got[$];
	oiwp_pkg::oiwp_word_t exp_q[$];
	logic [7:0] tx[$];
	int n_mismatch = 0;
	int n_checks = 0;
	int seed = 3;
	always #10 clk = ~clk;
	// Wired-and of master and acknowledge with pull-up.
	assign sda = sda_drv & (sda_oe_n | sda_out);
	oiwp_master m (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_drv(sda_drv));
	oiwp_top #(.FIFO_DEPTH(8)) dut (.i_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda),
		.i_slave_addr_select(sel_pin), .i_chip_init_n(init_n), .i_out_ready(rdy),
		.o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .o_out_valid(valid), .o_out_word(word),
		.o_overflow(ovf), .o_busy(busy), .o_display_on(disp_on), .o_mux_full(mux),
		.o_com_scan_normal(scan), .o_seg_map_normal(segmap), .o_start_line(sline),
		.o_column(col), .o_contrast(contrast), .o_display_normal(dnorm));
	// Consumer stalls at random or on demand.
	always @(negedge clk) rdy <= !stall && ($random(seed) % 4 != 0);
	always @(posedge clk) if (!rst && valid && rdy) got.push_back(word);
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk_bit(input logic e, input logic g);
		n_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_word(input oiwp_pkg::oiwp_word_t e, input oiwp_pkg::oiwp_word_t g);
		n_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	// Expected word for one routed byte.
	function automatic oiwp_pkg::oiwp_word_t word_of(logic d, logic [7:0] c, logic [7:0] v);
		return {d, c, v};
	endfunction
	task automatic ctrl(input logic cont, input logic s);
		tx.push_back({cont, s, 6'h00});
		e_sel = s;
	endtask
	task automatic put(input logic [7:0] v);
		tx.push_back(v);
		exp_q.push_back(word_of(e_sel, e_col, v));
		if (e_sel)
			e_col++;
	endtask
	task automatic run(input logic [7:0] a, input logic ok);
		logic ack;
		m.start_cond();
		m.send_byte(a, ack);
		chk_bit(ok, ack);
		foreach (tx[i]) begin m.send_byte(tx[i], ack); chk_bit(ok, ack); end
		m.stop_cond();
		tx.delete();
		chk_bit(1'b0, busy);
	endtask
	task automatic match;
		for (int k = 0; k < 300 && got.size() < exp_q.size(); k++) @(negedge clk);
		chk_byte(8'(exp_q.size()), 8'(got.size()));
		foreach (exp_q[i]) if (i < got.size()) chk_word(exp_q[i], got[i]);
		chk_byte(e_col, col);
		got.delete();
		exp_q.delete();
	endtask
	task automatic chk_init;
		chk_bit(1'b0, disp_on);
		chk_bit(1'b1, mux & scan);
		chk_bit(1'b1, segmap);
		chk_byte(8'h00, {2'h0, sline});
		chk_byte(8'h00, col);
		chk_byte(8'h80, contrast);
		chk_bit(1'b1, dnorm);
	endtask
	// Watchdog cuts a hang short.
	initial
	begin
		#1000000;
		n_mismatch++;
		wrap_up();
	end
	initial
	begin
		int n;
		e_col = 8'h00;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		repeat (5) @(negedge clk);
		chk_init();
		// Alternating control and single bytes, both routes.
		ctrl(1'b1, 1'b0);
		put(8'($random(seed)));
		ctrl(1'b1, 1'b1);
		put(8'h80);
		ctrl(1'b1, 1'b1);
		put(8'h40);
		run({oiwp_pkg::ADDR_BASE, sel_pin, oiwp_pkg::RW_WRITE}, 1'b1);
		match();
		for (int t = 0; t < 6; t++)
		begin
			sel_pin = 1'($random(seed));
			ctrl(1'b0, 1'($random(seed)));
			n = 1 + ($unsigned($random(seed)) % 5);
			repeat (n) put(8'($random(seed)));
			run({oiwp_pkg::ADDR_BASE, sel_pin, oiwp_pkg::RW_WRITE}, 1'b1);
			match();
		end
		// Other address, then a read request: both ignored.
		sel_pin = 1'b1;
		tx.push_back(8'h40);
		run({oiwp_pkg::ADDR_BASE, 1'b0, oiwp_pkg::RW_WRITE}, 1'b0);
		tx.push_back(8'h00);
		run({oiwp_pkg::ADDR_BASE, 1'b1, 1'b1}, 1'b0);
		match();
		// Stalled consumer: FIFO fills and refuses.
		stall = 1'b1;
		base = e_col;
		ctrl(1'b0, 1'b1);
		repeat (12) put(8'($random(seed)));
		run({oiwp_pkg::ADDR_BASE, sel_pin, oiwp_pkg::RW_WRITE}, 1'b1);
		chk_bit(1'b1, ovf);
		stall = 1'b0;
		for (int k = 0; k < 300 && valid !== 1'b0; k++) @(negedge clk);
		foreach (got[i]) chk_word(exp_q[i], got[i]);
		chk_bit(1'b1, got.size() >= 8);
		e_col = base + 8'(got.size());
		chk_byte(e_col, col);
		got.delete();
		exp_q.delete();
		// Chip init restores defaults.
		init_n = 1'b0;
		repeat (10) @(negedge clk);
		chk_init();
		chk_bit(1'b0, ovf);
		init_n = 1'b1;
		repeat (6) @(negedge clk);
		e_col = 8'h00;
		ctrl(1'b0, 1'b1);
		put(8'($random(seed)));
		put(8'hff);
		run({oiwp_pkg::ADDR_BASE, sel_pin, oiwp_pkg::RW_WRITE}, 1'b1);
		match();
		wrap_up();
	end
endmodule // oiwp_bench

// file: test/oiwp_chk.sv
// Purpose: Pin-level assertions for the write port.
// Assumes: Sees only the ports of oiwp_top.
// Notes: Bound to every oiwp_top instance.
module oiwp_chk (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_scl,
	input wire logic i_chip_init_n,
	input wire logic i_out_ready,
	input wire logic o_sda_out,
	input wire logic o_sda_oe_n,
	input wire logic o_out_valid,
	input wire oiwp_pkg::oiwp_word_t o_out_word,
	input wire logic o_overflow,
	input wire logic o_busy,
	input wire logic o_display_on,
	input wire logic o_mux_full,
	input wire logic o_com_scan_normal,
	input wire logic o_seg_map_normal,
	input wire logic [5:0] o_start_line,
	input wire logic [7:0] o_column,
	input wire logic [7:0] o_contrast,
	input wire logic o_display_normal
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// An acknowledge only ever pulls the line low.
	property p_ack_low; !o_sda_oe_n |-> !o_sda_out; endproperty
	a_ack_low: assert property (p_ack_low) else $error("ack drives high");
	property p_ack_busy; !o_sda_oe_n |-> o_busy; endproperty
	a_ack_busy: assert property (p_ack_busy) else $error("ack outside a transfer");
	// The acknowledge starts and ends while the clock is low.
	property p_ack_on; $fell(o_sda_oe_n) |-> !i_scl; endproperty
	a_ack_on: assert property (p_ack_on) else $error("ack starts in high phase");
	property p_ack_off; $rose(o_sda_oe_n) |-> !i_scl; endproperty
	a_ack_off: assert property (p_ack_off) else $error("ack ends in high phase");
	property p_col_step;
		$changed(o_column) |-> (o_column == $past(o_column) + 8'h01) || (o_column == 8'h00);
	endproperty
	a_col_step: assert property (p_col_step) else $error("column jumps");
	property p_hold; o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_word); endproperty
	a_hold: assert property (p_hold) else $error("word lost while stalled");
	// Eight cycles of init cover the synchroniser delay.
	property p_init_col; (!i_chip_init_n) [*8] |-> o_column == 8'h00 && !o_busy; endproperty
	a_init_col: assert property (p_init_col) else $error("init column");
	property p_init_disp;
		(!i_chip_init_n) [*8] |-> !o_display_on && o_mux_full && o_com_scan_normal;
	endproperty
	a_init_disp: assert property (p_init_disp) else $error("init display");
	property p_init_map;
		(!i_chip_init_n) [*8] |-> o_seg_map_normal && o_start_line == 6'h00 && o_display_normal
			&& o_contrast == 8'h80;
	endproperty
	a_init_map: assert property (p_init_map) else $error("init mapping");
	c_ack: cover property ($fell(o_sda_oe_n));
	c_step: cover property ($changed(o_column) && o_column != 8'h00);
	c_ovf: cover property ($rose(o_overflow));
	c_stall: cover property (o_out_valid && !i_out_ready);
endmodule // oiwp_chk
bind oiwp_top oiwp_chk u_chk (.i_clk, .i_rst, .i_scl, .i_chip_init_n, .i_out_ready, .o_sda_out,
	.o_sda_oe_n, .o_out_valid, .o_out_word, .o_overflow, .o_busy, .o_display_on, .o_mux_full,
	.o_com_scan_normal, .o_seg_map_normal, .o_start_line, .o_column, .o_contrast,
	.o_display_normal);

// file: test/oiwp_master.sv
// Purpose: Bus master model that writes bytes to the port.
// Assumes: Line is pulled up; a driven 1 means released.
// Notes: One SCL period is eight system clocks (160 ns): six low, two high.
module oiwp_master (
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_drv
);
	timeunit 1ns;
	timeprecision 1ns;
	// Low phase leaves room for the pin filter and the acknowledge pull-down.
	localparam int LOW = 6;
	// High phase is the shortest pulse that the pin filter still passes.
	localparam int HIGH = 2;
	// Bus free time after a stop, long enough for the busy flag to drop.
	localparam int GAP = 8;
	// Idle bus: both lines released.
	initial
	begin
		o_scl = 1'b1;
		o_sda_drv = 1'b1;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	task automatic start_cond;
		o_sda_drv = 1'b1;
		wait_clk(LOW / 2);
		o_scl = 1'b1;
		wait_clk(HIGH);
		o_sda_drv = 1'b0;
		wait_clk(HIGH);
		o_scl = 1'b0;
		wait_clk(LOW / 2);
	endtask
	task automatic stop_cond;
		o_sda_drv = 1'b0;
		wait_clk(LOW / 2);
		o_scl = 1'b1;
		wait_clk(HIGH);
		o_sda_drv = 1'b1;
		wait_clk(GAP);
	endtask
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic a0;
		for (int i = 8; i >= 0; i--)
		begin
			o_sda_drv = (i == 0) ? 1'b1 : b[i - 1];
			wait_clk(LOW / 2);
			o_scl = 1'b1;
			wait_clk(1);
			a0 = i_sda;
			wait_clk(HIGH - 1);
			ack = !a0 && !i_sda;
			o_scl = 1'b0;
			wait_clk(LOW / 2);
		end
	endtask
endmodule // oiwp_master
